// file: hw/rtcu_top.sv
// Update cycle, divider taps, clock out and multiplexed bus of the clock core.
// Assumes all pins arrive asynchronously; the wire level of AD is resolved outside.
//
// Implementation choices: the address map and strobed register access.
`timescale 1ns/1ps
`include "rtcu_defs.svh"

// Notes on behaviour
// - One update per second only with valid time base, running chain, inhibit clear.
// - Setting inhibit aborts a running update and blocks new ones.
// - Update increments seconds and carries through minutes, hours, days, months, year.
// - Alarm fires when all three alarm bytes match or hold wildcard 11xxxxxx.
// - Update lasts 248 us on megahertz bases, 1984 us on 32.768 kHz.
// - Time, calendar and alarm storage reads undefined and ignores writes during update.
// - Pending flag rises 244 us before update and stays high through it.
// - Update-ended event raised at end of every update, interrupt when enabled.
// - With chip enable negated all bus inputs are ignored.
// - Clock out follows time base when select high, quarter rate when low.
// - Square wave shows one of 15 chain taps, gated by its enable bit.
// - Address taken from low six bus lines at address strobe fall.
// - Device drives read data in strobe phase, releases per bus mode.
// - Data strobe level sampled at address strobe fall picks bus mode.
// - Low sample means strobe-style mode, high means read/write pulse mode.
// - Strobe mode: read/write is a level; pulse mode: active-low write pulse.
// - Divider bits pick base or hold chain; first update half second after release.
// - Year divisible by four is a leap year for February.
module rtcu_top #(
  parameter int unsigned UPD_LONG_CYC = `RTCU_UPD_LONG_CYC
) (
  // Clock and reset
  input  wire logic       CORE_CLK_I,
  input  wire logic       RST_B_I,
  // Time base and clock out
  input  wire logic       TIME_BASE_I,
  input  wire logic       CLK_OUT_DIV_SEL_I,
  output logic            CLK_OUT_O,
  output logic            SQUARE_WAVE_O,
  // Multiplexed host bus
  input  wire logic       CHIP_EN_B_I,
  input  wire logic       ADDR_STROBE_I,
  input  wire logic       DATA_STROBE_I,
  input  wire logic       READ_WRITE_I,
  input  wire logic [7:0] AD_I,
  output logic      [7:0] AD_O,
  output logic            AD_OE_O,
  // Status
  output logic            UPDATE_PENDING_O,
  output logic            UPDATE_IRQ_O
);

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function automatic logic [7:0] month_days(input logic [7:0] mon, input logic [7:0] yr);
    case (mon)
      8'h02:   month_days = (yr[1:0] == 2'h0) ? 8'h1d : 8'h1c;
      8'h04,
      8'h06,
      8'h09,
      8'h0b:   month_days = 8'h1e;
      default: month_days = 8'h1f;
    endcase
  endfunction

  function automatic rtcu_pkg::rtcu_time_t advance(input rtcu_pkg::rtcu_time_t t);
    rtcu_pkg::rtcu_time_t r;
    r = t;
    if (t[`RTCU_OFS_SEC] < 8'h3b) begin
      r[`RTCU_OFS_SEC] = t[`RTCU_OFS_SEC] + 8'h01;
    end else begin
      r[`RTCU_OFS_SEC] = 8'h00;
      if (t[`RTCU_OFS_MIN] < 8'h3b) begin
        r[`RTCU_OFS_MIN] = t[`RTCU_OFS_MIN] + 8'h01;
      end else begin
        r[`RTCU_OFS_MIN] = 8'h00;
        if (t[`RTCU_OFS_HR] < 8'h17) begin
          r[`RTCU_OFS_HR] = t[`RTCU_OFS_HR] + 8'h01;
        end else begin
          r[`RTCU_OFS_HR]  = 8'h00;
          r[`RTCU_OFS_DOW] = (t[`RTCU_OFS_DOW] >= 8'h07) ? 8'h01 : t[`RTCU_OFS_DOW] + 8'h01;
          if (t[`RTCU_OFS_DATE] < month_days(t[`RTCU_OFS_MON], t[`RTCU_OFS_YEAR])) begin
            r[`RTCU_OFS_DATE] = t[`RTCU_OFS_DATE] + 8'h01;
          end else begin
            r[`RTCU_OFS_DATE] = 8'h01;
            if (t[`RTCU_OFS_MON] < 8'h0c) begin
              r[`RTCU_OFS_MON] = t[`RTCU_OFS_MON] + 8'h01;
            end else begin
              r[`RTCU_OFS_MON]  = 8'h01;
              r[`RTCU_OFS_YEAR] = (t[`RTCU_OFS_YEAR] >= 8'h63) ? 8'h00
                                                              : t[`RTCU_OFS_YEAR] + 8'h01;
            end
          end
        end
      end
    end
    advance = r;
  endfunction

  function automatic logic alarm_pos(input logic [7:0] alm, input logic [7:0] now);
    alarm_pos = (alm[7:6] == `RTCU_WILDCARD) || (alm == now);
  endfunction

  function automatic logic [4:0] tap_index(input logic [3:0] rs, input logic slow);
    case (rs)
      4'h1:    tap_index = slow ? 5'h0d : 5'h06;
      4'h2:    tap_index = slow ? 5'h0e : 5'h07;
      default: tap_index = 5'({1'b0, rs} + 5'h05);
    endcase
  endfunction

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  rtcu_pkg::rtcu_state_s s;
  rtcu_pkg::rtcu_state_s n;
  rtcu_pkg::rtcu_pins_s  raw;
  rtcu_pkg::rtcu_pins_s  nf;
  rtcu_pkg::rtcu_time_t  adv;
  logic [2:0]            dv;
  logic                  dv_ok;
  logic                  run_ok;
  logic                  tb_rise;
  logic [22:0]           div_sum;
  logic [21:0]           div_step;
  logic                  tick;
  logic                  sel;
  logic                  rd_act;
  logic                  rd_start;
  logic                  wr_ev;
  logic [7:0]            rd_data;
  logic                  alarm_hit;
  logic                  upd_end;
  logic [14:0]           upd_cyc;

  assign raw = '{tb: TIME_BASE_I, clock_out_divide_select: CLK_OUT_DIV_SEL_I, ce_n: CHIP_EN_B_I,
                 as: ADDR_STROBE_I, ds: DATA_STROBE_I, rw: READ_WRITE_I, ad: AD_I};
  // Change accepted once second and third stage agree
  assign nf      = (s.s2 & s.s3) | (s.pin & (s.s2 ^ s.s3));
  assign dv      = s.reg_a[6:4];
  assign dv_ok   = (dv[2] == 1'b0) && (dv[1:0] != 2'h3);
  assign run_ok  = dv_ok && !s.reg_b[`RTCU_B_SET];
  assign tb_rise = !s.pin.tb && nf.tb;
  assign upd_cyc = (dv == 3'h2) ? 15'(UPD_LONG_CYC - 1) : 15'(`RTCU_UPD_SHORT_CYC - 1);
  assign adv     = advance(s.tm);
  assign upd_end = (s.st == rtcu_pkg::ST_UPD) && (s.cnt == 15'h0000) && !s.reg_b[`RTCU_B_SET];
  assign alarm_hit = alarm_pos(s.tm[`RTCU_OFS_SEC_ALM], adv[`RTCU_OFS_SEC])
                  && alarm_pos(s.tm[`RTCU_OFS_MIN_ALM], adv[`RTCU_OFS_MIN])
                  && alarm_pos(s.tm[`RTCU_OFS_HR_ALM], adv[`RTCU_OFS_HR]);

  // --------------------------------------------------------------------------
  // Divider chain
  // --------------------------------------------------------------------------
  always_comb begin
    case (dv)
      3'h1:    div_step = 22'h000004;
      3'h2:    div_step = 22'h000080;
      default: div_step = 22'h000001;
    endcase
  end
  assign div_sum = {1'b0, s.div} + {1'b0, div_step};
  assign tick    = tb_rise && dv_ok && div_sum[22];

  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------
  assign sel      = !s.pin.ce_n && !nf.ce_n;
  assign rd_act   = !nf.ce_n && !nf.as && !s.pin.as
                 && (s.strobe_mode ? (nf.ds && nf.rw) : !nf.ds);
  assign rd_start = rd_act && !s.ad_oe;
  assign wr_ev    = sel && (s.strobe_mode ? (s.pin.ds && !nf.ds && !s.pin.rw)
                                          : (!s.pin.rw && nf.rw));

  always_comb begin
    rd_data = 8'h00;
    case (s.addr)
      `RTCU_OFS_CTRL_A: rd_data = {s.update_pending_flag, s.reg_a};
      `RTCU_OFS_CTRL_B: rd_data = s.reg_b;
      `RTCU_OFS_FLAGS:  rd_data = {s.irq, 1'b0, s.af, s.uf, 4'h0};
      default: begin
        if (s.addr <= `RTCU_OFS_YEAR) begin
          rd_data = (s.st == rtcu_pkg::ST_UPD) ? `RTCU_UNDEF_DATA : s.tm[s.addr[3:0]];
        end
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    n     = s;
    n.s1  = raw;
    n.s2  = s.s1;
    n.s3  = s.s2;
    n.pin = nf;
    // Chain, clock out and square wave
    if (dv[2:1] == 2'h3) begin
      n.div = `RTCU_DIV_HOLD;
    end else if (tb_rise && dv_ok) begin
      n.div = div_sum[21:0];
    end
    if (tb_rise) begin
      n.ck_div = s.ck_div + 2'h1;
    end
    n.ck_out = nf.clock_out_divide_select ? nf.tb : s.ck_div[1];
    n.square_wave_pin    = s.reg_b[`RTCU_B_SQUARE_WAVE_OUTPUT_ENABLE] && (s.reg_a[3:0] != 4'h0)
            && s.div[tap_index(s.reg_a[3:0], dv == 3'h2)];
    // Update sequence
    case (s.st)
      rtcu_pkg::ST_IDLE: begin
        if (tick && run_ok) begin
          n.st  = rtcu_pkg::ST_PEND;
          n.cnt = 15'(`RTCU_PRE_UPD_CYC - 1);
          n.update_pending_flag = 1'b1;
        end
      end
      rtcu_pkg::ST_PEND: begin
        if (s.reg_b[`RTCU_B_SET]) begin
          n.st  = rtcu_pkg::ST_IDLE;
          n.update_pending_flag = 1'b0;
        end else if (s.cnt == 15'h0000) begin
          n.st  = rtcu_pkg::ST_UPD;
          n.cnt = upd_cyc;
        end else begin
          n.cnt = s.cnt - 15'h0001;
        end
      end
      rtcu_pkg::ST_UPD: begin
        if (s.reg_b[`RTCU_B_SET] || s.cnt == 15'h0000) begin
          n.st  = rtcu_pkg::ST_IDLE;
          n.update_pending_flag = 1'b0;
        end else begin
          n.cnt = s.cnt - 15'h0001;
        end
      end
      default: begin
        n.st  = rtcu_pkg::ST_IDLE;
        n.update_pending_flag = 1'b0;
      end
    endcase
    if (upd_end) begin
      n.tm = adv;
    end
    // Address phase
    if (sel && s.pin.as && !nf.as) begin
      n.addr        = s.pin.ad[5:0];
      n.strobe_mode = !s.pin.ds;
    end
    // Read phase
    n.ad_oe = rd_act;
    if (rd_start) begin
      n.ad_out = rd_data;
    end
    // Write phase
    if (wr_ev) begin
      case (s.addr)
        `RTCU_OFS_CTRL_A: n.reg_a = s.pin.ad[6:0];
        `RTCU_OFS_CTRL_B: n.reg_b = s.pin.ad;
        default: begin
          if (s.addr <= `RTCU_OFS_YEAR && s.st != rtcu_pkg::ST_UPD) begin
            n.tm[s.addr[3:0]] = s.pin.ad;
          end
        end
      endcase
    end
    // Flags: a setting event wins over the clearing read
    if (rd_start && s.addr == `RTCU_OFS_FLAGS) begin
      n.uf = 1'b0;
      n.af = 1'b0;
    end
    if (upd_end) begin
      n.uf = 1'b1;
      if (alarm_hit) begin
        n.af = 1'b1;
      end
    end
    n.irq = (n.uf && n.reg_b[`RTCU_B_UIE]) || (n.af && n.reg_b[`RTCU_B_AIE]);
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      s       <= '0;
      s.div   <= `RTCU_DIV_HOLD;
      s.st    <= rtcu_pkg::ST_IDLE;
      s.reg_a <= `RTCU_A_RST;
      s.reg_b <= `RTCU_B_RST;
      s.strobe_mode              <= 1'b1;
      s.tm[`RTCU_OFS_DOW]        <= 8'h01;
      s.tm[`RTCU_OFS_DATE]       <= 8'h01;
      s.tm[`RTCU_OFS_MON]        <= 8'h01;
    end else begin
      s <= n;
    end
  end

  assign CLK_OUT_O        = s.ck_out;
  assign SQUARE_WAVE_O    = s.square_wave_pin;
  assign AD_O             = s.ad_out;
  assign AD_OE_O          = s.ad_oe;
  assign UPDATE_PENDING_O = s.update_pending_flag;
  assign UPDATE_IRQ_O     = s.irq;
  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  logic [14:0] pend_len;
  logic [14:0] upd_len;
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      pend_len <= 15'h0000;
      upd_len  <= 15'h0000;
    end else begin
      pend_len <= (s.st == rtcu_pkg::ST_PEND) ? pend_len + 15'h0001 : 15'h0000;
      upd_len  <= (s.st == rtcu_pkg::ST_UPD) ? upd_len + 15'h0001 : 15'h0000;
    end
  end
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_B_I);
  chk_start_needs_run: assert property (
    (s.st == rtcu_pkg::ST_PEND && $past(s.st) == rtcu_pkg::ST_IDLE) |-> $past(run_ok && tick))
    else $error("update started without a running time base");
  chk_inhibit_aborts: assert property (
    (s.reg_b[`RTCU_B_SET] && s.st != rtcu_pkg::ST_IDLE) |=> s.st == rtcu_pkg::ST_IDLE && !s.update_pending_flag)
    else $error("inhibit did not abort the update");
  chk_seconds_step: assert property (
    (upd_end && s.tm[`RTCU_OFS_SEC] < 8'h3b)
      |=> s.tm[`RTCU_OFS_SEC] == $past(s.tm[`RTCU_OFS_SEC]) + 8'h01)
    else $error("seconds did not advance by one");
  chk_alarm_source: assert property (
    $rose(s.af) |-> $past(s.st) == rtcu_pkg::ST_UPD && $past(alarm_hit))
    else $error("alarm flag rose outside a matching update");
  chk_update_length: assert property (
    ($fell(s.st == rtcu_pkg::ST_UPD) && !$past(s.reg_b[`RTCU_B_SET]))
      |-> $past(upd_len) == $past(upd_cyc))
    else $error("update length wrong");
  chk_storage_isolated: assert property (
    (rd_start && s.st == rtcu_pkg::ST_UPD && s.addr <= `RTCU_OFS_YEAR)
      |=> s.ad_out == `RTCU_UNDEF_DATA)
    else $error("time storage readable during update");
  chk_pending_lead: assert property (
    $rose(s.st == rtcu_pkg::ST_UPD) |-> pend_len == 15'(`RTCU_PRE_UPD_CYC) && s.update_pending_flag)
    else $error("pending flag lead time wrong");
  chk_pending_through: assert property (
    (s.st == rtcu_pkg::ST_UPD) |-> s.update_pending_flag)
    else $error("pending flag dropped during update");
  chk_update_ended: assert property (
    ($fell(s.st == rtcu_pkg::ST_UPD) && !$past(s.reg_b[`RTCU_B_SET])) |-> s.uf)
    else $error("update-ended flag not raised");
  chk_ce_ignores: assert property (
    $past(s.pin.ce_n) |-> $stable(s.reg_a) && $stable(s.reg_b) && $stable(s.addr))
    else $error("bus acted while chip enable negated");
  chk_clock_out: assert property (
    (s.pin.clock_out_divide_select && $past(s.pin.clock_out_divide_select)) |-> s.ck_out == s.pin.tb)
    else $error("clock out does not follow time base");
  chk_square_off: assert property (
    !s.reg_b[`RTCU_B_SQUARE_WAVE_OUTPUT_ENABLE] |=> !s.square_wave_pin)
    else $error("square wave active while disabled");
  chk_addr_mode: assert property (
    (sel && s.pin.as && !nf.as) |=> s.addr == $past(s.pin.ad[5:0])
                                   && s.strobe_mode == !$past(s.pin.ds))
    else $error("address or bus mode not captured");
  chk_read_release: assert property (
    (s.strobe_mode && s.ad_oe && s.pin.ds && !nf.ds) |=> !s.ad_oe)
    else $error("read drive held after strobe fell");
  cov_update_done: cover property ($fell(s.st == rtcu_pkg::ST_UPD) && s.uf);
  cov_alarm: cover property ($rose(s.af));
  cov_read_strobe: cover property (rd_start && s.strobe_mode);
  cov_write_pulse: cover property (wr_ev && !s.strobe_mode);
endmodule

// file: hw/rtcu_defs.svh
// Offsets, field positions, reset values and timing counts of the update core.
// Assumes a 10 MHz core clock; included by the top module and the bench.
`ifndef RTCU_DEFS_SVH
`define RTCU_DEFS_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define RTCU_CLK_PERIOD_NS 100
`define RTCU_PRE_UPD_NS    244000
`define RTCU_UPD_SHORT_NS  248000
`define RTCU_UPD_LONG_NS   1984000
`define RTCU_PRE_UPD_CYC   ((`RTCU_PRE_UPD_NS + `RTCU_CLK_PERIOD_NS - 1) / `RTCU_CLK_PERIOD_NS)
`define RTCU_UPD_SHORT_CYC ((`RTCU_UPD_SHORT_NS + `RTCU_CLK_PERIOD_NS - 1) / `RTCU_CLK_PERIOD_NS)
`define RTCU_UPD_LONG_CYC  ((`RTCU_UPD_LONG_NS + `RTCU_CLK_PERIOD_NS - 1) / `RTCU_CLK_PERIOD_NS)

// ----------------------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------------------
`define RTCU_OFS_SEC     6'h00
`define RTCU_OFS_SEC_ALM 6'h01
`define RTCU_OFS_MIN     6'h02
`define RTCU_OFS_MIN_ALM 6'h03
`define RTCU_OFS_HR      6'h04
`define RTCU_OFS_HR_ALM  6'h05
`define RTCU_OFS_DOW     6'h06
`define RTCU_OFS_DATE    6'h07
`define RTCU_OFS_MON     6'h08
`define RTCU_OFS_YEAR    6'h09
`define RTCU_OFS_CTRL_A  6'h0a
`define RTCU_OFS_CTRL_B  6'h0b
`define RTCU_OFS_FLAGS   6'h0c

// ----------------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------------
`define RTCU_A_PEND      7
`define RTCU_B_SET       7
`define RTCU_B_AIE       5
`define RTCU_B_UIE       4
`define RTCU_B_SQUARE_WAVE_OUTPUT_ENABLE      3
`define RTCU_A_RST       7'h00
`define RTCU_B_RST       8'h00
`define RTCU_DIV_HOLD    22'h200000
`define RTCU_WILDCARD    2'h3
`define RTCU_UNDEF_DATA  8'hff
`endif

// file: hw/rtcu_pkg.sv
// Types shared by the update core.
// Assumes the constants header is on the include path.
package rtcu_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_PEND = 3'b010,
    ST_UPD  = 3'b100
  } rtcu_state_e;

  typedef logic [9:0][7:0] rtcu_time_t;

  typedef struct packed {
    logic       tb;
    logic       clock_out_divide_select;
    logic       ce_n;
    logic       as;
    logic       ds;
    logic       rw;
    logic [7:0] ad;
  } rtcu_pins_s;

  typedef struct packed {
    rtcu_pins_s  s1;
    rtcu_pins_s  s2;
    rtcu_pins_s  s3;
    rtcu_pins_s  pin;
    logic [21:0] div;
    logic [1:0]  ck_div;
    logic        ck_out;
    logic        square_wave_pin;
    rtcu_state_e st;
    logic [14:0] cnt;
    logic        update_pending_flag;
    rtcu_time_t  tm;
    logic [6:0]  reg_a;
    logic [7:0]  reg_b;
    logic        uf;
    logic        af;
    logic        irq;
    logic [5:0]  addr;
    logic        strobe_mode;
    logic [7:0]  ad_out;
    logic        ad_oe;
  } rtcu_state_s;
endpackage

// file: test/rtcu_host.sv
// Host processor model on the multiplexed address/data bus of the clock core.
// Assumes one core clock; the bench sets the phase length and calls cyc.
`timescale 1ns/1ps
module rtcu_host (
  // Clock
  input  wire logic       clk_i,
  // Device side of the bus
  input  wire logic [7:0] dev_ad_i,
  input  wire logic       dev_oe_i,
  // Host pins
  output logic            ce_b_o,
  output logic            as_o,
  output logic            ds_o,
  output logic            rw_o,
  output logic [7:0]      bus_o
);
  logic [7:0] drv    = 8'h00;
  logic       drv_en = 1'b0;
  logic [7:0] last   = 8'h00;
  int         ph     = 8;

  initial begin
    ce_b_o = 1'b1;
    as_o   = 1'b0;
    ds_o   = 1'b0;
    rw_o   = 1'b1;
  end

  // Released bus shows a pattern changing every cycle
  assign bus_o = dev_oe_i ? dev_ad_i : (drv_en ? drv : ~last);
  always @(posedge clk_i) last <= bus_o;

  // -------------------------------------------------------------------------
  // One bus cycle: pm selects pulse mode, wr a write, ceb the chip enable
  // -------------------------------------------------------------------------
  task automatic cyc(input logic pm, input logic wr, input logic ceb,
                     input logic [5:0] a, input logic [7:0] d,
                     output logic [7:0] q, output logic oe);
    @(posedge clk_i);
    ce_b_o <= ceb;
    as_o   <= 1'b1;
    ds_o   <= pm;
    rw_o   <= 1'b1;
    drv    <= {2'h3, a};
    drv_en <= 1'b1;
    repeat (ph) @(posedge clk_i);
    as_o <= 1'b0;
    repeat (ph) @(posedge clk_i);
    drv    <= d;
    drv_en <= wr;
    if (pm) begin
      if (wr) rw_o <= 1'b0;
      else ds_o <= 1'b0;
    end else begin
      rw_o <= ~wr;
      ds_o <= 1'b1;
    end
    repeat (2 * ph) @(posedge clk_i);
    q = bus_o;
    oe = dev_oe_i;
    ds_o <= pm;
    if (pm) rw_o <= 1'b1;
    repeat (ph) @(posedge clk_i);
    drv_en <= 1'b0;
    ce_b_o <= 1'b1;
    rw_o   <= 1'b1;
  endtask
endmodule

// file: test/rtc_update_cycle_bus_control_tb.sv
// Self-checking bench of the clock core: bus modes, clock out, square wave, update.
// Assumes the host model and a 2.5 MHz time base made here; short update length.
`timescale 1ns/1ps
`include "rtcu_defs.svh"
`define CHK(a, b) \
  begin \
    checked++; \
    if ((a) !== (b)) begin \
      n_fail++; \
      $display("[ERR] %0t got %h want %h", $time, a, b); \
    end \
  end
module rtc_update_cycle_bus_control_tb;
  logic       clk = 1'b0;
  logic       rst_b = 1'b0;
  logic       tbase = 1'b0;
  logic       sel = 1'b1;
  logic       ce_b, as_s, ds_s, rw_s, ck_o, sq_o, oe_o, pend, irq;
  logic [7:0] ad_i, ad_o, q;
  logic       oe;
  int         checked = 0, n_fail = 0, tb_n = 0, ck_n = 0, sq_n = 0, pd = 0;
  logic [7:0] ld [10] = '{8'h3b, 8'h00, 8'h3b, 8'h00, 8'h17, 8'hc0, 8'h03, 8'h1f, 8'h0c, 8'h03};
  logic [7:0] ex [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hc0, 8'h04, 8'h01, 8'h01, 8'h04};

  rtcu_top #(.UPD_LONG_CYC(200)) rtcu_top_i (
    .CORE_CLK_I(clk), .RST_B_I(rst_b), .TIME_BASE_I(tbase),
    .CLK_OUT_DIV_SEL_I(sel), .CLK_OUT_O(ck_o), .SQUARE_WAVE_O(sq_o),
    .CHIP_EN_B_I(ce_b), .ADDR_STROBE_I(as_s), .DATA_STROBE_I(ds_s),
    .READ_WRITE_I(rw_s), .AD_I(ad_i), .AD_O(ad_o), .AD_OE_O(oe_o),
    .UPDATE_PENDING_O(pend), .UPDATE_IRQ_O(irq));
  rtcu_host rtcu_host_i (
    .clk_i(clk), .dev_ad_i(ad_o), .dev_oe_i(oe_o), .ce_b_o(ce_b),
    .as_o(as_s), .ds_o(ds_s), .rw_o(rw_s), .bus_o(ad_i));

  // -------------------------------------------------------------------------
  // Clock, time base and edge counters
  // -------------------------------------------------------------------------
  initial begin
    forever #50 clk = ~clk;
  end
  initial begin
    forever begin
      repeat (2) @(posedge clk);
      tbase <= ~tbase;
    end
  end
  always @(posedge tbase) tb_n++;
  always @(posedge ck_o) ck_n++;
  always @(posedge sq_o) sq_n++;
  always @(negedge clk) if (pend === 1'b1) pd++;

  // -------------------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------------------
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic bound(input int n, input int lim);
    if (n >= lim) begin
      n_fail++;
      $display("[ERR] %0t wait ran out", $time);
      finish_test();
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    rtcu_host_i.cyc(1'b0, 1'b1, 1'b0, a, d, q, oe);
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    rtcu_host_i.cyc(1'b0, 1'b0, 1'b0, a, 8'h00, q, oe);
    `CHK(oe, 1'b1)
    `CHK(q, e)
  endtask

  // -------------------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------------------
  task automatic t_reset();
    `CHK(pend, 1'b0)
    `CHK(oe_o, 1'b0)
    rd(`RTCU_OFS_CTRL_A, 8'h00);
    rd(`RTCU_OFS_CTRL_B, 8'h00);
    rd(`RTCU_OFS_DATE, 8'h01);
  endtask

  task automatic t_bus();
    wr(`RTCU_OFS_SEC_ALM, 8'h5a);
    rd(`RTCU_OFS_SEC_ALM, 8'h5a);
    `CHK(oe_o, 1'b0)
    rtcu_host_i.ph = 12;
    rtcu_host_i.cyc(1'b1, 1'b1, 1'b0, `RTCU_OFS_MIN_ALM, 8'ha5, q, oe);
    rtcu_host_i.cyc(1'b1, 1'b0, 1'b0, `RTCU_OFS_MIN_ALM, 8'h00, q, oe);
    `CHK(q, 8'ha5)
    `CHK(oe_o, 1'b0)
    rtcu_host_i.ph = 8;
    rtcu_host_i.cyc(1'b0, 1'b1, 1'b1, `RTCU_OFS_MIN_ALM, 8'h3c, q, oe);
    rtcu_host_i.cyc(1'b0, 1'b0, 1'b1, `RTCU_OFS_MIN_ALM, 8'h00, q, oe);
    `CHK(oe, 1'b0)
    rd(`RTCU_OFS_MIN_ALM, 8'ha5);
  endtask

  task automatic t_clk();
    int n;
    int e;
    for (int s = 0; s < 2; s++) begin
      sel <= s[0];
      e = (s == 1) ? 64 : 16;
      repeat (16) @(posedge clk);
      n = ck_n;
      repeat (256) @(posedge clk);
      `CHK((ck_n - n) inside {[e - 2:e + 2]}, 1'b1)
    end
  endtask

  task automatic t_upd();
    int t0;
    int n;
    wr(`RTCU_OFS_CTRL_B, 8'h80);
    wr(`RTCU_OFS_CTRL_A, 8'h70);
    for (int i = 0; i < 10; i++) wr(i[5:0], ld[i]);
    wr(`RTCU_OFS_CTRL_A, 8'h23);
    t0 = tb_n;
    wr(`RTCU_OFS_CTRL_B, 8'h38);
    for (int k = 0; k < 3; k++) begin
      wr(`RTCU_OFS_CTRL_A, (k == 1) ? 8'h20 : 8'h23);
      wr(`RTCU_OFS_CTRL_B, (k == 2) ? 8'h30 : 8'h38);
      n = sq_n;
      repeat (512) @(posedge clk);
      `CHK((sq_n - n) > 0, k == 0)
    end
    for (n = 0; n < 80000 && pend !== 1'b1; n++) @(negedge clk);
    bound(n, 80000);
    `CHK((tb_n - t0) inside {[16376:16392]}, 1'b1)
    repeat (100) @(posedge clk);
    rd(`RTCU_OFS_SEC, 8'h3b);
    repeat (2330) @(posedge clk);
    rd(`RTCU_OFS_SEC, `RTCU_UNDEF_DATA);
    for (n = 0; n < 400 && pend === 1'b1; n++) @(negedge clk);
    bound(n, 400);
    `CHK(pd inside {[2637:2643]}, 1'b1)
    `CHK(irq, 1'b1)
    for (int i = 0; i < 10; i++) rd(i[5:0], ex[i]);
    rd(`RTCU_OFS_FLAGS, 8'hb0);
    `CHK(irq, 1'b0)
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset();
    t_bus();
    t_clk();
    t_upd();
    finish_test();
  end
endmodule
